// ===== rtl/sadc_ctrl.sv
// control, sequencing and register file of the 8-bit converter
// Summary of operation
// - eight-bit result built by successive approximation, one bit per step
// - sequencer timed by the main clock divided by twelve
// - conversion lasts about seventy microseconds at eight megahertz
// - writing start begins a conversion and clears the done flag; here only if power was already on and stays on
// - done flag set at completion; result valid only while it is set
// - one conversion per start, then idle
// - start during a conversion abandons it and begins anew
// - start bit is write-only and reads as zero
// - interrupt request when done flag set and enable bit is one
// - done flag read-only, doubles as interrupt pending
// - power bit one enables converter, zero powers it down
// - converter keeps running in wait; its interrupt wakes the core
// - reset stops conversion, control becomes 40h, interrupt masked
// - result register at d0h is read-only, all eight bits
// - in wait with timer stopped only converter and oscillator run
//
// Local design decision: the strobed register port.
`default_nettype none
module sadc_ctrl #(
  parameter int SETTLE_TICKS = sadc_pkg::SETTLE_TICKS,
  parameter int BIT_TICKS = sadc_pkg::BIT_TICKS
) (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  input wire logic cmp_i,
  output logic [7:0] dac_o,
  output logic power_o,
  output logic active_o,
  output logic irq_o
);

  // ---------------------------------------------------------------
  // parameter checks and local constants
  // ---------------------------------------------------------------
  if (SETTLE_TICKS < 1 || SETTLE_TICKS > 255 || BIT_TICKS < 1 || BIT_TICKS > 255) begin : g_bad
    $error("tick counts must lie between 1 and 255");
  end

  localparam logic [7:0] SETTLE_LAST = 8'(SETTLE_TICKS - 1);
  localparam logic [7:0] BIT_LAST = 8'(BIT_TICKS - 1);

  sadc_pkg::sadc_top_s state_ff;
  sadc_pkg::sadc_top_s nxt_state;

  logic tick;
  logic ctrl_wr;
  logic start_go;
  logic bit_step;
  logic [7:0] trial;
  logic [7:0] decided;
  logic last_bit;

  // ---------------------------------------------------------------
  // bus decode
  // ---------------------------------------------------------------
  // control readback with write-only and unused bits forced
  function automatic logic [7:0] ctrl_view(input sadc_pkg::sadc_top_s s);
    ctrl_view = '0;
    ctrl_view[sadc_pkg::CTRL_IRQ_EN_BIT] = s.irq_en;
    ctrl_view[sadc_pkg::CTRL_EOC_BIT] = s.eoc;
    ctrl_view[sadc_pkg::CTRL_START_BIT] = 1'b0;
    ctrl_view[sadc_pkg::CTRL_POWER_BIT] = s.power;
    ctrl_view[3:0] = sadc_pkg::CTRL_UNUSED_READ;
  endfunction

  assign ctrl_wr = wr_i && (addr_i == sadc_pkg::CTRL_ADDR);
  // start needs prior power
  // start is honoured only when power was already on and stays on
  assign start_go = ctrl_wr && wdata_i[sadc_pkg::CTRL_START_BIT] && state_ff.power
                    && wdata_i[sadc_pkg::CTRL_POWER_BIT];

  assign bit_step = (state_ff.phase == sadc_pkg::SADC_BITS) && tick
                    && (state_ff.tcnt == BIT_LAST) && !start_go && state_ff.power;

  // ---------------------------------------------------------------
  // leaves
  // ---------------------------------------------------------------
  // divided sequencer clock
  sadc_tick_div #(
    .DIV(sadc_pkg::CLK_DIV)
  ) u_div (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .restart_i(start_go),
    .tick_o(tick)
  );

  sadc_sar_step u_sar (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .clear_i(start_go),
    .step_i(bit_step),
    .cmp_i(cmp_i),
    .trial_o(trial),
    .decided_o(decided),
    .last_o(last_bit)
  );

  // ---------------------------------------------------------------
  // sequencer and register file
  // ---------------------------------------------------------------
  // one state copy; start outranks completion in the same cycle
  always_comb begin
    nxt_state = state_ff;
    nxt_state.rdata = sadc_pkg::READ_IDLE;
    if (ctrl_wr) begin
      nxt_state.irq_en = wdata_i[sadc_pkg::CTRL_IRQ_EN_BIT];
      nxt_state.power = wdata_i[sadc_pkg::CTRL_POWER_BIT];
    end
    unique case (state_ff.phase)
      sadc_pkg::SADC_IDLE: begin
        nxt_state.tcnt = 8'h00;
      end
      sadc_pkg::SADC_SETTLE: begin
        if (tick) begin
          if (state_ff.tcnt == SETTLE_LAST) begin
            nxt_state.phase = sadc_pkg::SADC_BITS;
            nxt_state.tcnt = 8'h00;
          end else begin
            nxt_state.tcnt = state_ff.tcnt + 8'h01;
          end
        end
      end
      sadc_pkg::SADC_BITS: begin
        if (tick) begin
          if (state_ff.tcnt == BIT_LAST) begin
            nxt_state.tcnt = 8'h00;
          end else begin
            nxt_state.tcnt = state_ff.tcnt + 8'h01;
          end
        end
        if (bit_step && last_bit) begin
          nxt_state.phase = sadc_pkg::SADC_IDLE;
          nxt_state.eoc = 1'b1;
          nxt_state.result = decided;
        end
      end
      default: begin
        nxt_state.phase = sadc_pkg::SADC_IDLE;
      end
    endcase
    if (!nxt_state.power) begin
      nxt_state.phase = sadc_pkg::SADC_IDLE;
      nxt_state.tcnt = 8'h00;
    end
    if (start_go) begin
      nxt_state.phase = sadc_pkg::SADC_SETTLE;
      nxt_state.tcnt = 8'h00;
      nxt_state.eoc = 1'b0;
    end
    if (rd_i) begin
      if (addr_i == sadc_pkg::CTRL_ADDR) begin
        nxt_state.rdata = ctrl_view(state_ff);
      end else if (addr_i == sadc_pkg::RESULT_ADDR) begin
        nxt_state.rdata = state_ff.result;
      end
    end
    nxt_state.irq = nxt_state.irq_en && nxt_state.eoc;
    nxt_state.active = nxt_state.phase != sadc_pkg::SADC_IDLE;
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      state_ff.phase <= sadc_pkg::SADC_IDLE;
      state_ff.tcnt <= 8'h00;
      state_ff.irq_en <= sadc_pkg::CTRL_RESET[sadc_pkg::CTRL_IRQ_EN_BIT];
      state_ff.eoc <= sadc_pkg::CTRL_RESET[sadc_pkg::CTRL_EOC_BIT];
      state_ff.power <= sadc_pkg::CTRL_RESET[sadc_pkg::CTRL_POWER_BIT];
      state_ff.result <= sadc_pkg::RESULT_RESET;
      state_ff.rdata <= sadc_pkg::READ_IDLE;
      state_ff.irq <= 1'b0;
      state_ff.active <= 1'b0;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  // dac code comes from the sar flip-flops, power and flags from ours
  assign rdata_o = state_ff.rdata;
  assign dac_o = trial;
  assign power_o = state_ff.power;
  assign active_o = state_ff.active;
  assign irq_o = state_ff.irq;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  localparam logic [15:0] CONV_LEN = 16'(sadc_pkg::CLK_DIV * (SETTLE_TICKS + 8 * BIT_TICKS));

  // helper: cycles spent since the last accepted start
  logic [15:0] run_cnt_ff;
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      run_cnt_ff <= 16'h0000;
    end else if (start_go) begin
      run_cnt_ff <= 16'h0000;
    end else if (state_ff.active && run_cnt_ff != 16'hffff) begin
      run_cnt_ff <= run_cnt_ff + 16'h0001;
    end
  end

  sequence s_start;
    start_go;
  endsequence

  sequence s_running;
    !state_ff.eoc && state_ff.active;
  endsequence

  property p_start_clears;
    @(posedge mclk_i) disable iff (rst_i)
      s_start |=> s_running [*8];
  endproperty
  a_start_clears: assert property (p_start_clears) else $error("start did not clear flag");

  property p_conv_length;
    @(posedge mclk_i) disable iff (rst_i)
      $rose(state_ff.eoc) |-> run_cnt_ff == CONV_LEN;
  endproperty
  a_conv_length: assert property (p_conv_length) else $error("conversion length wrong");

  property p_result_with_flag;
    @(posedge mclk_i) disable iff (rst_i)
      $rose(state_ff.eoc) |-> $past(bit_step) && state_ff.result == $past(decided);
  endproperty
  a_result_with_flag: assert property (p_result_with_flag) else $error("result not loaded");

  property p_idle_stays;
    @(posedge mclk_i) disable iff (rst_i)
      !state_ff.active && !start_go |=> !state_ff.active;
  endproperty
  a_idle_stays: assert property (p_idle_stays) else $error("converter left idle alone");

  property p_start_reads_zero;
    @(posedge mclk_i) disable iff (rst_i)
      rd_i && addr_i == sadc_pkg::CTRL_ADDR |=> rdata_o[5] == 1'b0 && rdata_o[3:0] == 4'h0;
  endproperty
  a_start_reads_zero: assert property (p_start_reads_zero) else $error("ctrl readback bad");

  property p_irq_follows;
    @(posedge mclk_i) disable iff (rst_i)
      ##1 irq_o == (state_ff.irq_en && state_ff.eoc);
  endproperty
  a_irq_follows: assert property (p_irq_follows) else $error("interrupt mismatch");

  property p_power_down;
    @(posedge mclk_i) disable iff (rst_i)
      !power_o |-> !active_o;
  endproperty
  a_power_down: assert property (p_power_down) else $error("active while powered down");

  property p_restart;
    @(posedge mclk_i) disable iff (rst_i)
      state_ff.phase == sadc_pkg::SADC_BITS && start_go |=>
        state_ff.phase == sadc_pkg::SADC_SETTLE && dac_o == 8'h80;
  endproperty
  a_restart: assert property (p_restart) else $error("restart not taken");

  property p_result_read;
    @(posedge mclk_i) disable iff (rst_i)
      rd_i && addr_i == sadc_pkg::RESULT_ADDR |=> rdata_o == $past(state_ff.result);
  endproperty
  a_result_read: assert property (p_result_read) else $error("result readback bad");

  // one completion: a bit step on the last bit
  sequence s_done;
    bit_step && last_bit;
  endsequence

  // done flag stays up until a start is accepted
  property p_flag_holds;
    @(posedge mclk_i) disable iff (rst_i)
      state_ff.eoc && !start_go |=> state_ff.eoc;
  endproperty
  a_flag_holds: assert property (p_flag_holds) else $error("done flag dropped");

  // a bus write to bit six must never raise the flag
  property p_flag_only_done;
    @(posedge mclk_i) disable iff (rst_i)
      !state_ff.eoc && !(bit_step && last_bit) |=> !state_ff.eoc;
  endproperty
  a_flag_only_done: assert property (p_flag_only_done) else $error("flag set early");

  property p_done_idle;
    @(posedge mclk_i) disable iff (rst_i)
      s_done |=> state_ff.eoc && !active_o;
  endproperty
  a_done_idle: assert property (p_done_idle) else $error("no idle after completion");

  // result only moves at a completion, so a late read still sees it
  property p_result_stable;
    @(posedge mclk_i) disable iff (rst_i)
      !(bit_step && last_bit) |=> $stable(state_ff.result);
  endproperty
  a_result_stable: assert property (p_result_stable) else $error("result moved");

  // after a tick, no second tick comes within the next eight cycles
  property p_tick_gap;
    @(posedge mclk_i) disable iff (rst_i)
      tick |=> !tick [*8];
  endproperty
  a_tick_gap: assert property (p_tick_gap) else $error("tick too early");

  property p_rdata_idle;
    @(posedge mclk_i) disable iff (rst_i)
      !rd_i |=> rdata_o == sadc_pkg::READ_IDLE;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data not idle");

  property p_cold_start;
    @(posedge mclk_i) disable iff (rst_i)
      ctrl_wr && !power_o |=> !active_o;
  endproperty
  a_cold_start: assert property (p_cold_start) else $error("start while off");

  property p_irq_masked;
    @(posedge mclk_i) disable iff (rst_i)
      !state_ff.irq_en && !ctrl_wr |=> !irq_o;
  endproperty
  a_irq_masked: assert property (p_irq_masked) else $error("request not masked");

endmodule
`default_nettype wire

// ===== rtl/sadc_pkg.sv
// shared constants and types for the successive-approximation converter control
`default_nettype none
package sadc_pkg;

  // ---------------------------------------------------------------
  // register map and field positions
  // ---------------------------------------------------------------
  localparam logic [7:0] RESULT_ADDR = 8'hd0;
  localparam logic [7:0] CTRL_ADDR = 8'hd1;
  localparam int CTRL_IRQ_EN_BIT = 7;
  localparam int CTRL_EOC_BIT = 6;
  localparam int CTRL_START_BIT = 5;
  localparam int CTRL_POWER_BIT = 4;
  localparam logic [7:0] CTRL_RESET = 8'h40;
  localparam logic [3:0] CTRL_UNUSED_READ = 4'h0;
  localparam logic [7:0] RESULT_RESET = 8'h00;
  localparam logic [7:0] READ_IDLE = 8'h00;

  // ---------------------------------------------------------------
  // conversion timing
  // ---------------------------------------------------------------
  localparam int RES_BITS = 8;
  localparam int CLK_DIV = 12;
  localparam int CONV_TIME_NS = 70000;
  localparam int OSC_KHZ = 8000;
  // typical length in divided ticks, rounded down
  localparam int CONV_TICKS = (CONV_TIME_NS * OSC_KHZ) / (CLK_DIV * 1000000);
  localparam int BIT_TICKS = CONV_TICKS / RES_BITS;
  localparam int SETTLE_TICKS = CONV_TICKS - (BIT_TICKS * RES_BITS);
  localparam int CONV_MCLK = CONV_TICKS * CLK_DIV;

  // ---------------------------------------------------------------
  // state carriers
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    SADC_IDLE,
    SADC_SETTLE,
    SADC_BITS
  } sadc_phase_e;

  typedef struct packed {
    logic [7:0] code;
    logic [7:0] mask;
  } sadc_sar_s;

  typedef struct packed {
    logic [3:0] cnt;
  } sadc_div_s;

  typedef struct packed {
    sadc_phase_e phase;
    logic [7:0] tcnt;
    logic irq_en;
    logic eoc;
    logic power;
    logic [7:0] result;
    logic [7:0] rdata;
    logic irq;
    logic active;
  } sadc_top_s;

endpackage
`default_nettype wire

// ===== rtl/sadc_tick_div.sv
// divide-by-n tick generator for the conversion sequencer
`default_nettype none
module sadc_tick_div #(
  parameter int DIV = sadc_pkg::CLK_DIV
) (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic restart_i,
  output logic tick_o
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  localparam logic [3:0] LAST = 4'(DIV - 1);
  sadc_pkg::sadc_div_s state_ff;
  sadc_pkg::sadc_div_s nxt_state;

  if (DIV < 2 || DIV > 16) begin : g_bad_div
    $error("divider must lie between 2 and 16");
  end

  // restart realigns the phase so every conversion has the same length
  always_comb begin
    nxt_state = state_ff;
    if (restart_i || state_ff.cnt == LAST) begin
      nxt_state.cnt = 4'h0;
    end else begin
      nxt_state.cnt = state_ff.cnt + 4'h1;
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      state_ff <= '0;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // one-cycle tick at the end of each divided period
  assign tick_o = (state_ff.cnt == LAST) && !restart_i;

endmodule
`default_nettype wire

// ===== rtl/sadc_sar_step.sv
// successive approximation register, most significant bit first
`default_nettype none
module sadc_sar_step (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic clear_i,
  input wire logic step_i,
  input wire logic cmp_i,
  output logic [7:0] trial_o,
  output logic [7:0] decided_o,
  output logic last_o
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  localparam logic [7:0] FIRST = 8'h80;
  sadc_pkg::sadc_sar_s state_ff;
  sadc_pkg::sadc_sar_s nxt_state;

  // keep the trial bit when the input is at or above the trial level
  function automatic logic [7:0] decide(input logic [7:0] code, input logic [7:0] mask,
                                        input logic keep);
    decide = keep ? code : (code & ~mask);
  endfunction

  // clear loads mid-scale; each step fixes one bit and tries the next
  always_comb begin
    nxt_state = state_ff;
    if (clear_i) begin
      nxt_state.code = FIRST;
      nxt_state.mask = FIRST;
    end else if (step_i) begin
      nxt_state.code = decide(state_ff.code, state_ff.mask, cmp_i) | (state_ff.mask >> 1);
      nxt_state.mask = state_ff.mask >> 1;
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      state_ff <= '0;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign trial_o = state_ff.code;
  assign decided_o = decide(state_ff.code, state_ff.mask, cmp_i);
  assign last_o = state_ff.mask[0];

endmodule
`default_nettype wire

// ===== verification/sadc_cmp_model.sv
// comparator model fed by the one selected analog input
`default_nettype none
module sadc_cmp_model (
  input wire logic mclk_i,
  input wire logic power_i,
  input wire logic [7:0] dac_i,
  input wire logic [7:0] vin_i,
  output logic cmp_o
);
  timeunit 1ns;
  timeprecision 1ns;

  // ---------------------------------------------
  // comparator
  // ---------------------------------------------
  logic junk_ff = 1'b0;

  // unpowered comparator answers nothing useful: toggle so a stale value never looks valid
  always_ff @(posedge mclk_i) begin
    junk_ff <= ~junk_ff;
  end

  assign cmp_o = power_i ? (vin_i >= dac_i) : junk_ff;
endmodule
`default_nettype wire

// ===== verification/test_sadc_ctrl.sv
// self-checking bench for the converter control block
`default_nettype none
module test_sadc_ctrl;
  timeunit 1ns;
  timeprecision 1ns;

  // ---------------------------------------------
  // setup
  // ---------------------------------------------
  // short sequence keeps the run brief; all timing expectations follow from these
  localparam int S = 2;
  localparam int B = 2;
  localparam int CONV = sadc_pkg::CLK_DIV * (S + 8 * B);
  localparam logic [7:0] CA = sadc_pkg::CTRL_ADDR;
  localparam logic [7:0] RA = sadc_pkg::RESULT_ADDR;
  logic mclk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [7:0] addr_i = 8'h00;
  logic [7:0] wdata_i = 8'h00;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic [7:0] rdata_o;
  logic cmp_i;
  logic [7:0] dac_o;
  logic power_o;
  logic active_o;
  logic irq_o;
  logic [7:0] vin = 8'h00;
  integer seed = 32'haec4;
  int n_mismatch = 0;
  int total_checks = 0;
  logic m_en, m_eoc, m_pwr;
  logic [7:0] m_res;
  logic [7:0] rd_val;
  int cycles;

  // clock
  always #50 mclk_i = ~mclk_i;

  sadc_ctrl #(.SETTLE_TICKS(S), .BIT_TICKS(B)) i_sadc_ctrl (
    .mclk_i(mclk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
    .rd_i(rd_i), .rdata_o(rdata_o), .cmp_i(cmp_i), .dac_o(dac_o), .power_o(power_o),
    .active_o(active_o), .irq_o(irq_o));

  sadc_cmp_model i_sadc_cmp_model (
    .mclk_i(mclk_i), .power_i(power_o), .dac_i(dac_o), .vin_i(vin), .cmp_o(cmp_i));

  // ---------------------------------------------
  // tasks
  // ---------------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  function automatic logic [7:0] m_ctrl();
    return {m_en, m_eoc, 1'b0, m_pwr, 4'h0};
  endfunction

  task automatic results();
    $display("checks=%0d mismatches=%0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // write cycle; also steps the bench model of the control register
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge mclk_i);
    wr_i <= 1'b0;
    if (a == CA) begin
      if (m_pwr && d[5] && d[4]) m_eoc = 1'b0;
      m_en = d[7];
      m_pwr = d[4];
    end
    #1;
  endtask

  // read cycle; data taken in the one cycle it stands
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    @(posedge mclk_i);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge mclk_i);
    rd_i <= 1'b0;
    #1;
    d = rdata_o;
  endtask

  // start one conversion, follow every trial code and time the completion
  task automatic run_conv(input logic [7:0] d);
    logic [7:0] code;
    logic [7:0] trial [8];
    logic [7:0] last;
    int idx;
    code = 8'h00;
    for (int k = 0; k < 8; k++) begin
      trial[k] = code | (8'h80 >> k);
      if (vin >= trial[k]) code = trial[k];
    end
    wr_reg(CA, d);
    chk(dac_o, 8'h80);
    chk(active_o, 1'b1);
    chk(irq_o, 1'b0);
    idx = 1;
    last = 8'h80;
    cycles = 0;
    while (cycles < CONV + 20 && active_o !== 1'b0) begin
      @(posedge mclk_i);
      #1;
      cycles++;
      if (dac_o !== last && idx < 8 && active_o === 1'b1) begin
        chk(dac_o, trial[idx]);
        idx++;
        last = dac_o;
      end
    end
    if (active_o !== 1'b0) begin
      n_mismatch++;
      results();
    end
    m_eoc = 1'b1;
    m_res = code;
    chk(16'(cycles), 16'(CONV));
    chk(irq_o, m_en);
    rd_reg(CA, rd_val);
    chk(rd_val, m_ctrl());
    rd_reg(RA, rd_val);
    chk(rd_val, m_res);
    chk(rd_val, vin);
  endtask

  // ---------------------------------------------
  // main sequence
  // ---------------------------------------------
  initial begin
    m_en = 1'b0;
    m_eoc = 1'b1;
    m_pwr = 1'b0;
    m_res = sadc_pkg::RESULT_RESET;
    repeat (10) @(posedge mclk_i);
    rst_i <= 1'b0;
    #1;
    chk({power_o, active_o, irq_o}, 3'b000);
    rd_reg(CA, rd_val);
    chk(rd_val, sadc_pkg::CTRL_RESET);
    rd_reg(RA, rd_val);
    chk(rd_val, m_res);
    @(posedge mclk_i);
    #1;
    chk(rdata_o, sadc_pkg::READ_IDLE);
    rd_reg(8'hd2, rd_val);
    chk(rd_val, sadc_pkg::READ_IDLE);
    $display("test reset done");
    // start while powered down does nothing
    wr_reg(CA, 8'h20);
    chk(active_o, 1'b0);
    rd_reg(CA, rd_val);
    chk(rd_val, m_ctrl());
    // power first, then start
    wr_reg(CA, 8'h10);
    chk(power_o, 1'b1);
    for (int i = 0; i < 4; i++) begin
      vin = (i == 0) ? 8'h00 : (i == 1) ? 8'hff : 8'($random(seed));
      run_conv(i[0] ? 8'hb0 : 8'h30);
      repeat (CONV / 4) @(posedge mclk_i);
      #1;
      chk(active_o, 1'b0);
      if (i == 1) begin
        wr_reg(CA, 8'h10);
        chk(irq_o, 1'b0);
        wr_reg(CA, 8'h90);
        chk(irq_o, 1'b1);
      end
    end
    $display("test conversions done");
    // restart in mid conversion
    wr_reg(CA, 8'h30);
    repeat (40) @(posedge mclk_i);
    rd_reg(CA, rd_val);
    chk(rd_val, m_ctrl());
    vin = 8'($random(seed));
    run_conv(8'hb0);
    $display("test restart done");
    // unused bits and the read-only result
    wr_reg(CA, 8'h9f);
    rd_reg(CA, rd_val);
    chk(rd_val, m_ctrl());
    wr_reg(RA, 8'h5a);
    rd_reg(RA, rd_val);
    chk(rd_val, m_res);
    $display("test read-only done");
    // power-down aborts, done flag cannot be written
    wr_reg(CA, 8'h30);
    repeat (30) @(posedge mclk_i);
    wr_reg(CA, 8'h40);
    chk({active_o, power_o}, 2'b00);
    repeat (CONV) @(posedge mclk_i);
    rd_reg(CA, rd_val);
    chk(rd_val, m_ctrl());
    $display("test power-down done");
    // reset in mid conversion
    wr_reg(CA, 8'h10);
    wr_reg(CA, 8'hb0);
    repeat (30) @(posedge mclk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge mclk_i);
    rst_i <= 1'b0;
    m_en = 1'b0;
    m_eoc = 1'b1;
    m_pwr = 1'b0;
    #1;
    chk({power_o, active_o, irq_o}, 3'b000);
    rd_reg(CA, rd_val);
    chk(rd_val, sadc_pkg::CTRL_RESET);
    rd_reg(RA, rd_val);
    chk(rd_val, sadc_pkg::RESULT_RESET);
    chk(dac_o, 8'h00);
    $display("test reset in flight done");
    results();
  end
endmodule
`default_nettype wire
